// ===== adc_port_pkg.sv
`default_nettype none
package adc_port_pkg;
	localparam int CHANNELS = 8;
	localparam int CODE_W = 16;
	localparam int RAW_W = 18;
	localparam int FRAME_W = 152;
	localparam int GPIO_N = 4;
	localparam int TIMER_W = 16;
	localparam logic [3:0] STATUS_HEAD = 4'hC;
	localparam logic [CODE_W-1:0] CODE_MAX = 16'h7FFF;
	localparam logic [CODE_W-1:0] CODE_MIN = 16'h8000;
	localparam logic [CODE_W-1:0] CODE_OFF = 16'h0000;
	localparam logic [RAW_W-1:0] RAW_MAX = 18'h07FFF;
	localparam logic [RAW_W-1:0] RAW_MIN = 18'h38000;
	localparam logic [7:0] OP_START = 8'h08;
	localparam logic [7:0] OP_STOP = 8'h0A;
	localparam logic [7:0] OP_RESET = 8'h06;
	localparam logic [7:0] OP_READ_CONT = 8'h10;
	localparam logic [7:0] OP_STOP_CONT = 8'h11;
	localparam logic [7:0] OP_RDATA = 8'h12;
	// bit counter value at the seventh and eighth falling edge
	localparam logic [2:0] EDGE_SEVENTH = 3'h6;
	localparam logic [2:0] EDGE_EIGHTH = 3'h7;
	localparam logic [7:0] FRAME_LAST = 8'h97;
	localparam logic [7:0] FRAME_FIRST = 8'h00;
	localparam int CLK_MHZ = 100;
	localparam int INIT_CYCLES = 18;
	// oscillator and reference wake-up, plain default
	localparam int WAKE_TIME_US = 100;
	localparam int WAKE_CYCLES_DEF = WAKE_TIME_US * CLK_MHZ;
	localparam logic [GPIO_N-1:0] GPIO_DIR_RESET = 4'hF;
	localparam logic [GPIO_N-1:0] GPIO_LEVEL_RESET = 4'h0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	typedef logic [RAW_W-1:0] raw_type;
	typedef struct packed {
		logic [CHANNELS-1:0] pos;
		logic [CHANNELS-1:0] neg;
	} fault_type;
	// direction bit 1 means input
	typedef struct packed {
		logic [GPIO_N-1:0] dir;
		logic [GPIO_N-1:0] level;
	} gpio_write_type;
	typedef enum logic [1:0] {
		PH_DOWN = 2'b00,
		PH_INIT = 2'b01,
		PH_IDLE = 2'b10,
		PH_RUN  = 2'b11
	} phase_type;
endpackage
`default_nettype wire

// ===== adc_serial_data_port.sv
// Function
// - select pin 0 uses external clock; 1 internal, clock pin driven if enabled
// - channel results are 16-bit two's complement, msb first
// - results clip at 7FFFh and 8000h without wrap
// - zero input gives 0000h, one step gives 0001h or FFFFh
// - select high resets serial state, ignores clock and data, floats output
// - ready output falls on each new conversion, whatever the select level
// - every eight falling edges form one instruction; select toggle realigns
// - data in sampled on falling edges, data out shifted on rising edges
// - frame msb appears on the first rising edge of a read
// - ready output returns high on the first serial falling edge
// - frame is 24 status bits then eight 16-bit channels in order
// - status opens 1100, positive faults, negative faults, pin levels
// - powered-down channel reads zero, slot order unchanged
// - with chain enable set, extra clocks restart the frame from its start
// - single read stays intact across the next ready event
// - in continuous mode data out also shows new data ready
// - four pins, own direction bits, inputs after reset, read real levels
// - power-down low stops conversion and holds ready high; rising resumes after wake-up time
// - reset pin or opcode on eighth edge; 18 clocks to restart
// - first config change resets filter; converts only after start
// - powers up continuous; opcodes 10h, 11h, 12h decoded
// - start and stop opcodes act on the seventh falling edge
`timescale 1ns/10ps
`default_nettype none
module adc_serial_data_port
	import adc_port_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
)(
	input  wire logic                              clk_in,
	input  wire logic                              rst_in,
	input  wire logic                              sclk_in,
	input  wire logic                              cs_n_in,
	input  wire logic                              din_in,
	output logic                                   dout_out,
	output logic                                   dout_oe_n_out,
	output logic                                   conversion_ready_n_out,
	input  wire logic                              clock_source_select_pin_in,
	input  wire logic                              clock_out_enable_in,
	output logic                                   clk_pin_out,
	output logic                                   clk_pin_oe_n_out,
	output logic                                   use_internal_osc_out,
	input  wire logic                              power_down_n_in,
	input  wire logic                              reset_n_in,
	input  wire logic                              start_in,
	input  wire logic                              chain_enable_in,
	input  wire logic [7:0]                        first_config_register_in,
	input  wire logic [CHANNELS-1:0]               channel_power_down_in,
	input  wire raw_type [CHANNELS-1:0]            sample_in,
	input  wire logic                              sample_valid_in,
	input  wire fault_type                         faults_in,
	input  wire gpio_write_type                    pin_write_in,
	input  wire logic                              pin_write_valid_in,
	input  wire logic [GPIO_N-1:0]                 gpio_in,
	output logic [GPIO_N-1:0]                      gpio_out,
	output logic [GPIO_N-1:0]                      gpio_oe_n_out,
	output logic [GPIO_N-1:0]                      pin_level_bits_out,
	output logic                                   filter_reset_out,
	output logic                                   converting_out,
	output logic                                   powered_down_out,
	output logic                                   continuous_read_mode_out
);
	typedef struct packed {
		phase_type            phase;
		logic [TIMER_W-1:0]   timer;
		logic                 run_cmd;
		logic                 ready_n;
		logic                 filt_rst;
		logic                 pending;
		logic                 clk_div;
		logic [1:0]           rst_s;
		logic [1:0]           pd_s;
		logic [1:0]           sel_s;
		logic [1:0]           busy_s;
		logic [2:0]           start_s;
		logic [2:0]           tog_start_s;
		logic [2:0]           tog_stop_s;
		logic [2:0]           tog_reset_s;
		logic [2:0]           tog_fall_s;
		logic [GPIO_N-1:0]    gpio_s1;
		logic [GPIO_N-1:0]    gpio_s2;
		logic [GPIO_N-1:0]    dir;
		logic [GPIO_N-1:0]    level;
		logic [7:0]           cfg_prev;
		logic [FRAME_W-1:0]   latest;
		logic [FRAME_W-1:0]   out_frame;
	} core_type;
	// link state cleared by select high
	typedef struct packed {
		logic [6:0] shift;
		logic [2:0] cnt;
		logic       rd_cmd;
		logic       rd_live;
	} rx_type;
	// link state that must survive select high
	typedef struct packed {
		logic cont;
		logic tog_start;
		logic tog_stop;
		logic tog_reset;
		logic tog_fall;
	} cmd_type;
	typedef struct packed {
		logic [7:0] idx;
		logic       started;
		logic       done;
		logic       busy;
		logic       dout;
	} tx_type;

	core_type                            q;
	core_type                            d;
	rx_type                              rx_q;
	rx_type                              rx_d;
	cmd_type                             cmd_q;
	cmd_type                             cmd_d;
	tx_type                              tx_q;
	tx_type                              tx_d;
	logic [0:CHANNELS-1][CODE_W-1:0]     codes;
	logic [FRAME_W-1:0]                  frame_w;
	logic                                link_rst;
	logic [7:0]                          rx_byte;
	logic                                read_on;
	logic                                run_req;

	for (genvar i = 0; i < CHANNELS; i++)
	begin : g_chan
		assign codes[i] = channel_power_down_in[i] ? CODE_OFF :
			($signed(sample_in[i]) > $signed(RAW_MAX)) ? CODE_MAX :
			($signed(sample_in[i]) < $signed(RAW_MIN)) ? CODE_MIN :
			sample_in[i][CODE_W-1:0];
	end
	assign frame_w = {STATUS_HEAD, faults_in.pos, faults_in.neg, q.gpio_s2, codes};
	assign run_req = q.start_s[1] | q.run_cmd;

	always_comb
	begin
		d = q;
		d.filt_rst = 1'b0;
		d.clk_div = ~q.clk_div;
		d.rst_s = {q.rst_s[0], reset_n_in};
		d.pd_s = {q.pd_s[0], power_down_n_in};
		d.sel_s = {q.sel_s[0], clock_source_select_pin_in};
		d.busy_s = {q.busy_s[0], tx_q.busy};
		d.start_s = {q.start_s[1:0], start_in};
		d.tog_start_s = {q.tog_start_s[1:0], cmd_q.tog_start};
		d.tog_stop_s = {q.tog_stop_s[1:0], cmd_q.tog_stop};
		d.tog_reset_s = {q.tog_reset_s[1:0], cmd_q.tog_reset};
		d.tog_fall_s = {q.tog_fall_s[1:0], cmd_q.tog_fall};
		d.gpio_s1 = gpio_in;
		d.gpio_s2 = q.gpio_s1;
		d.cfg_prev = first_config_register_in;
		if (q.tog_fall_s[2] != q.tog_fall_s[1])
			d.ready_n = 1'b1;
		if (first_config_register_in != q.cfg_prev)
			d.filt_rst = 1'b1;
		if (q.tog_stop_s[2] != q.tog_stop_s[1])
			d.run_cmd = 1'b0;
		if ((q.tog_start_s[2] != q.tog_start_s[1]) || (q.start_s[1] && !q.start_s[2]))
		begin
			d.run_cmd = q.run_cmd | (q.tog_start_s[2] != q.tog_start_s[1]);
			d.ready_n = 1'b1;
			d.filt_rst = 1'b1;
		end
		if (pin_write_valid_in)
		begin
			d.dir = pin_write_in.dir;
			d.level = (pin_write_in.level & ~pin_write_in.dir) | (q.level & pin_write_in.dir);
		end
		case (q.phase)
			PH_DOWN:
			begin
				d.phase = PH_INIT;
				d.timer = TIMER_W'(WAKE_CYCLES + INIT_CYCLES);
			end
			PH_INIT:
			begin
				d.timer = q.timer - 1'b1;
				if (q.timer <= TIMER_W'(1))
				begin
					d.phase = PH_IDLE;
					d.filt_rst = 1'b1;
				end
			end
			PH_IDLE:
			begin
				if (run_req)
				begin
					d.phase = PH_RUN;
					d.ready_n = 1'b1;
				end
			end
			PH_RUN:
			begin
				if (sample_valid_in)
				begin
					d.latest = frame_w;
					d.pending = 1'b1;
					d.ready_n = 1'b0;
					if (!run_req)
						d.phase = PH_IDLE;
				end
			end
			default:
			begin
				d.phase = PH_INIT;
				d.timer = TIMER_W'(INIT_CYCLES);
			end
		endcase
		// a frame on its way out is never overwritten
		if (!q.busy_s[1] && q.pending)
		begin
			d.out_frame = q.latest;
			d.pending = (q.phase == PH_RUN) && sample_valid_in;                      // new sample stays pending
		end
		if (!q.pd_s[1])
		begin
			d.phase = PH_DOWN;
			d.ready_n = 1'b1;
			d.run_cmd = 1'b0;
		end
		else if (!q.rst_s[1] || (q.tog_reset_s[2] != q.tog_reset_s[1]))
		begin
			d.phase = PH_INIT;
			d.timer = TIMER_W'(INIT_CYCLES);
			d.run_cmd = 1'b0;
			d.ready_n = 1'b1;
			d.dir = GPIO_DIR_RESET;
			d.level = GPIO_LEVEL_RESET;
		end
		if (q.phase == PH_DOWN && q.pd_s[1] == 1'b0)
			d.timer = q.timer;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			q <= '0;
			q.phase <= PH_INIT;
			q.timer <= TIMER_W'(INIT_CYCLES);
			q.ready_n <= 1'b1;
			q.dir <= GPIO_DIR_RESET;
			q.level <= GPIO_LEVEL_RESET;
			q.cfg_prev <= CFG_RESET;
			q.rst_s <= 2'h3;
			q.pd_s <= 2'h3;
		end
		else
			q <= d;
	end

	assign link_rst = rst_in | cs_n_in;
	assign rx_byte = {rx_q.shift, din_in};

	always_comb
	begin
		rx_d = rx_q;
		cmd_d = cmd_q;
		rx_d.shift = rx_byte[6:0];
		rx_d.cnt = rx_q.cnt + 3'h1;
		if (!cs_n_in)
			cmd_d.tog_fall = ~cmd_q.tog_fall;
		if (rx_q.cnt == EDGE_SEVENTH)
		begin
			if (rx_byte[6:0] == OP_START[7:1])
				cmd_d.tog_start = ~cmd_q.tog_start;
			if (rx_byte[6:0] == OP_STOP[7:1])
				cmd_d.tog_stop = ~cmd_q.tog_stop;
			if (rx_byte[6:0] == OP_RDATA[7:1])
				rx_d.rd_cmd = 1'b1;
		end
		if (rx_q.cnt == EDGE_EIGHTH)
		begin
			rx_d.rd_live = rx_q.rd_cmd;
			if (rx_byte == OP_READ_CONT)
				cmd_d.cont = 1'b1;
			if (rx_byte == OP_STOP_CONT)
				cmd_d.cont = 1'b0;
			if (rx_byte == OP_RESET)
			begin
				cmd_d.tog_reset = ~cmd_q.tog_reset;
				cmd_d.cont = 1'b1;
			end
		end
	end

	always_ff @(negedge sclk_in or posedge link_rst)
	begin
		if (link_rst)
			rx_q <= '0;
		else
			rx_q <= rx_d;
	end

	always_ff @(negedge sclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cmd_q <= '0;
			cmd_q.cont <= 1'b1;
		end
		else if (!cs_n_in)
			cmd_q <= cmd_d;
	end

	// out_frame is held still by the core while busy is seen there
	assign read_on = cmd_q.cont | rx_q.rd_live;

	always_comb
	begin
		tx_d = tx_q;
		if (read_on && !tx_q.done)
		begin
			tx_d.started = 1'b1;
			tx_d.busy = 1'b1;
			tx_d.dout = q.out_frame[FRAME_LAST - tx_q.idx];
			tx_d.idx = tx_q.idx + 8'h01;
			if (tx_q.idx == FRAME_LAST)
			begin
				tx_d.idx = FRAME_FIRST;
				tx_d.done = ~chain_enable_in;
				tx_d.busy = chain_enable_in;
			end
		end
		else if (tx_q.done)
			tx_d.dout = 1'b0;
	end

	always_ff @(posedge sclk_in or posedge link_rst)
	begin
		if (link_rst)
			tx_q <= '0;
		else
			tx_q <= tx_d;
	end

	assign dout_out = tx_q.started ? tx_q.dout : (cmd_q.cont & q.ready_n);
	assign dout_oe_n_out = cs_n_in;
	assign conversion_ready_n_out = q.ready_n;
	assign use_internal_osc_out = q.sel_s[1];
	assign clk_pin_out = q.clk_div;
	assign clk_pin_oe_n_out = ~(q.sel_s[1] & clock_out_enable_in);
	assign gpio_out = q.level;
	assign gpio_oe_n_out = q.dir;
	assign pin_level_bits_out = q.gpio_s2;
	assign filter_reset_out = q.filt_rst;
	assign converting_out = (q.phase == PH_RUN);
	assign powered_down_out = (q.phase == PH_DOWN);
	assign continuous_read_mode_out = cmd_q.cont;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	a_clip_high: assert property ((q.phase == PH_RUN && sample_valid_in && !channel_power_down_in[0]
		&& $signed(sample_in[0]) > $signed(RAW_MAX)) |=> q.latest[127:112] == CODE_MAX)
		else $error("positive clip code wrong");
	a_clip_low: assert property ((q.phase == PH_RUN && sample_valid_in && !channel_power_down_in[1]
		&& $signed(sample_in[1]) < $signed(RAW_MIN)) |=> q.latest[111:96] == CODE_MIN)
		else $error("negative clip code wrong");
	a_off_zero: assert property ((q.phase == PH_RUN && sample_valid_in && channel_power_down_in[7])
		|=> q.latest[15:0] == CODE_OFF)
		else $error("powered-down slot not zero");
	a_status_head: assert property ($changed(q.latest) |-> q.latest[151:148] == STATUS_HEAD)
		else $error("status head pattern wrong");
	a_ready_fall: assert property ((q.phase == PH_RUN && sample_valid_in && q.pd_s[1] && q.rst_s[1]
		&& q.tog_reset_s[2] == q.tog_reset_s[1]) |=> !conversion_ready_n_out)
		else $error("ready not asserted on new data");
	a_ready_cause: assert property ($fell(conversion_ready_n_out) |-> $past(q.phase) == PH_RUN
		&& $past(sample_valid_in))
		else $error("ready fell without conversion");
	a_ready_clear: assert property ((q.tog_fall_s[2] != q.tog_fall_s[1] && !(q.phase == PH_RUN
		&& sample_valid_in)) |=> conversion_ready_n_out)
		else $error("ready not cleared by serial edge");
	a_init_len: assert property (($fell(q.rst_s[1]) && q.pd_s[1]) |=> q.phase == PH_INIT
		##0 q.timer == TIMER_W'(INIT_CYCLES))
		else $error("reset did not load init count");
	a_init_end: assert property ((q.phase == PH_INIT && q.timer == TIMER_W'(1) && q.rst_s[1]
		&& q.pd_s[1] && q.tog_reset_s[2] == q.tog_reset_s[1]) |=> q.phase == PH_IDLE ##0 filter_reset_out)
		else $error("init did not end on count");
	a_pin_input: assert property (q.phase != PH_DOWN && !q.rst_s[1] |=> gpio_oe_n_out == GPIO_DIR_RESET)
		else $error("pins not inputs after reset");
	a_clk_drive: assert property (clk_pin_oe_n_out == !(q.sel_s[1] && clock_out_enable_in))
		else $error("clock pin drive wrong");
	a_down_halt: assert property (!q.pd_s[1] |=> powered_down_out && conversion_ready_n_out)
		else $error("power-down not entered");
	a_msb_first: assert property (@(posedge sclk_in) disable iff (link_rst)
		(read_on && !tx_q.started) |=> dout_out == $past(q.out_frame[151]))
		else $error("frame msb not first");

	c_new_frame: cover property (q.phase == PH_RUN && sample_valid_in);
	c_readback: cover property (@(posedge sclk_in) tx_q.idx == FRAME_LAST && chain_enable_in);
	c_wake: cover property ($rose(q.pd_s[1]) ##1 q.phase == PH_INIT);
endmodule
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/10ps
`default_nettype none
// serial master on the far side; its clock stands low outside frames
module host_model (
	input  wire logic clk_in,
	input  wire logic dout_in,
	input  wire logic dout_oe_n_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      din_out
);
	logic rx [0:167];
	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		din_out = 1'b0;
	end
	task automatic select_dev();
		#7;
		cs_n_out = 1'b0;
		#24;
	endtask
	// 48 ns bit period ships a whole frame far inside one data period
	task automatic shift(input int base, input int n, input logic [7:0] cmd);
		for (int i = 0; i < n; i++)
		begin
			din_out = (i < 8) ? cmd[7-i] : 1'b0;
			sclk_out = 1'b1;
			#24;
			rx[base+i] = dout_oe_n_in ? 1'bx : dout_in;
			sclk_out = 1'b0;
			#24;
		end
	endtask
	task automatic deselect();
		repeat (5) @(posedge clk_in);
		#1;
		cs_n_out = 1'b1;
		din_out = 1'b0;
		#44; // returns on a master clock falling edge
	endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top
	import adc_port_pkg::*;
;
	localparam raw_type [CHANNELS-1:0] SET_A = {18'h01234, 18'h38000, 18'h07FFF, 18'h3FFFF,
		18'h00001, 18'h00000, 18'h20000, 18'h1FFFF};
	localparam raw_type [CHANNELS-1:0] SET_B = {18'h00F00, 18'h3F000, 18'h00042, 18'h3FFFE,
		18'h07FFE, 18'h38001, 18'h00100, 18'h3FF00};
	localparam logic [2:0] CLK_TAB [3] = '{3'b011, 3'b101, 3'b110};
	logic                   clk_in, rst_in, sclk_in, cs_n_in, din_in, dout_out, dout_oe_n_out;
	logic                   conversion_ready_n_out, clock_source_select_pin_in, clock_out_enable_in;
	logic                   clk_pin_out, clk_pin_oe_n_out, use_internal_osc_out, power_down_n_in;
	logic                   reset_n_in, start_in, chain_enable_in, sample_valid_in, pin_write_valid_in;
	logic                   filter_reset_out, converting_out, powered_down_out, continuous_read_mode_out;
	logic [7:0]             first_config_register_in, channel_power_down_in;
	raw_type [CHANNELS-1:0] sample_in;
	fault_type              faults_in;
	gpio_write_type         pin_write_in;
	logic [GPIO_N-1:0]      gpio_in, gpio_out, gpio_oe_n_out, pin_level_bits_out, gpio_drv;
	logic [151:0]           exp_a, exp_b;
	int                     num_errors = 0;
	int                     compares = 0;
	// pins driven by the block win; the rest follow the board drive
	assign gpio_in = (gpio_out & ~gpio_oe_n_out) | (gpio_drv & gpio_oe_n_out);
	adc_serial_data_port #(.WAKE_CYCLES(20)) i_adc_serial_data_port (.clk_in, .rst_in, .sclk_in,
		.cs_n_in, .din_in, .dout_out, .dout_oe_n_out, .conversion_ready_n_out, .clock_source_select_pin_in,
		.clock_out_enable_in, .clk_pin_out, .clk_pin_oe_n_out, .use_internal_osc_out, .power_down_n_in,
		.reset_n_in, .start_in, .chain_enable_in, .first_config_register_in, .channel_power_down_in,
		.sample_in, .sample_valid_in, .faults_in, .pin_write_in, .pin_write_valid_in, .gpio_in, .gpio_out,
		.gpio_oe_n_out, .pin_level_bits_out, .filter_reset_out, .converting_out, .powered_down_out,
		.continuous_read_mode_out);
	host_model i_host_model (.clk_in, .dout_in(dout_out), .dout_oe_n_in(dout_oe_n_out),
		.sclk_out(sclk_in), .cs_n_out(cs_n_in), .din_out(din_in));
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	function automatic logic [151:0] make_frame(input raw_type [CHANNELS-1:0] s, input logic [3:0] lv);
		logic [151:0] fr;
		fr[151:128] = {4'hC, faults_in.pos, faults_in.neg, lv};
		for (int i = 0; i < CHANNELS; i++)
		begin
			if (channel_power_down_in[i])
				fr[127-16*i -: 16] = 16'h0000;
			else if ($signed(s[i]) >= $signed(18'h07FFF))
				fr[127-16*i -: 16] = 16'h7FFF;
			else if ($signed(s[i]) <= $signed(18'h38000))
				fr[127-16*i -: 16] = 16'h8000;
			else
				fr[127-16*i -: 16] = s[i][15:0];
		end
		return fr;
	endfunction
	task automatic give_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_conv(input logic want, input int n);
		for (int i = 0; i < n && converting_out !== want; i++)
			@(negedge clk_in);
		`CHK(converting_out, want);
	endtask
	task automatic pulse_sample(input raw_type [CHANNELS-1:0] s);
		@(negedge clk_in);
		sample_in = s;
		sample_valid_in = 1'b1;
		@(negedge clk_in);
		sample_valid_in = 1'b0;
	endtask
	task automatic send_cmd(input logic [7:0] op);
		i_host_model.select_dev();
		i_host_model.shift(0, 8, op);
		i_host_model.deselect();
		repeat (8) @(negedge clk_in);
	endtask
	task automatic gpio_write(input logic [7:0] v);
		@(negedge clk_in);
		pin_write_in = v;
		pin_write_valid_in = 1'b1;
		@(negedge clk_in);
		pin_write_valid_in = 1'b0;
		repeat (4) @(negedge clk_in);
	endtask
	task automatic check_frame(input int off, input logic [151:0] fr);
		for (int i = 0; i < 152; i++)
			`CHK(i_host_model.rx[off+i], fr[151-i]);
	endtask
	task automatic t_setup();
		bit seen;
		logic p;
		`CHK({conversion_ready_n_out, gpio_oe_n_out, continuous_read_mode_out}, 6'h3F);
		`CHK(dout_oe_n_out, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			@(negedge clk_in);
			{clock_source_select_pin_in, clock_out_enable_in} = CLK_TAB[i][2:1];
			repeat (4) @(negedge clk_in);
			`CHK({use_internal_osc_out, clk_pin_oe_n_out}, {CLK_TAB[i][2], CLK_TAB[i][0]});
		end
		p = clk_pin_out;
		@(negedge clk_in);
		`CHK(clk_pin_out, ~p);
		pulse_sample(SET_A);
		repeat (3) @(negedge clk_in);
		`CHK(conversion_ready_n_out, 1'b1);
		first_config_register_in = 8'h5A;
		seen = 1'b0;
		repeat (8) @(negedge clk_in) seen |= (filter_reset_out === 1'b1);
		`CHK(seen, 1'b1);
	endtask
	task automatic t_reads();
		start_in = 1'b1;
		wait_conv(1'b1, 20);
		pulse_sample(SET_A);
		repeat (2) @(negedge clk_in);
		`CHK(conversion_ready_n_out, 1'b0);
		i_host_model.select_dev();
		`CHK({dout_oe_n_out, dout_out}, 2'b00);
		i_host_model.shift(0, 1, 8'h00);
		repeat (6) @(negedge clk_in);
		`CHK(conversion_ready_n_out, 1'b1);
		i_host_model.shift(1, 151, 8'h00);
		i_host_model.deselect();
		check_frame(0, exp_a);
		`CHK(dout_oe_n_out, 1'b1);
		chain_enable_in = 1'b1;
		i_host_model.select_dev();
		i_host_model.shift(0, 160, 8'h00);
		i_host_model.deselect();
		chain_enable_in = 1'b0;
		for (int i = 0; i < 8; i++)
			`CHK(i_host_model.rx[152+i], exp_a[151-i]);
		// a broken transfer must not leave the next one misaligned
		i_host_model.select_dev();
		i_host_model.shift(0, 5, 8'h00);
		i_host_model.deselect();
		i_host_model.select_dev();
		i_host_model.shift(0, 8, 8'h00);
		i_host_model.deselect();
		for (int i = 0; i < 8; i++)
			`CHK(i_host_model.rx[i], exp_a[151-i]);
	endtask
	task automatic t_on_demand();
		send_cmd(8'h11);
		`CHK(continuous_read_mode_out, 1'b0);
		// a cut byte of 10h must not pair with the next byte into a mode change
		i_host_model.select_dev();
		i_host_model.shift(0, 5, 8'h10);
		i_host_model.deselect();
		send_cmd(8'h00);
		`CHK(continuous_read_mode_out, 1'b0);
		i_host_model.select_dev();
		fork
			i_host_model.shift(0, 160, 8'h12);
			begin
				repeat (300) @(negedge clk_in);
				pulse_sample(SET_B);
			end
		join
		i_host_model.deselect();
		check_frame(8, exp_a);
		i_host_model.select_dev();
		i_host_model.shift(0, 160, 8'h12);
		i_host_model.deselect();
		check_frame(8, exp_b);
		send_cmd(8'h10);
		`CHK(continuous_read_mode_out, 1'b1);
	endtask
	task automatic t_control();
		gpio_write(8'h35);
		`CHK({gpio_oe_n_out, gpio_out, pin_level_bits_out}, 12'h346);
		start_in = 1'b0;
		send_cmd(8'h08);
		send_cmd(8'h0A);
		pulse_sample(SET_A);
		repeat (4) @(negedge clk_in);
		`CHK(converting_out, 1'b0);
		send_cmd(8'h08);
		`CHK(converting_out, 1'b1);
		send_cmd(8'h06);
		repeat (24) @(negedge clk_in);
		`CHK({gpio_oe_n_out, converting_out}, 5'h1E);
		gpio_write(8'h30);
		reset_n_in = 1'b0;
		repeat (4) @(negedge clk_in);
		reset_n_in = 1'b1;
		repeat (24) @(negedge clk_in);
		`CHK(gpio_oe_n_out, 4'hF);
		power_down_n_in = 1'b0;
		repeat (5) @(negedge clk_in);
		`CHK({powered_down_out, converting_out}, 2'b10);
		power_down_n_in = 1'b1;
		start_in = 1'b1;
		repeat (20) @(negedge clk_in);
		`CHK(converting_out, 1'b0);
		wait_conv(1'b1, 40);
		`CHK(powered_down_out, 1'b0);
	endtask
	initial
	begin
		#500000;
		num_errors++;
		$display("Error at %0t: run timed out", $time);
		give_verdict();
	end
	initial
	begin
		rst_in = 1'b1;
		{clock_source_select_pin_in, clock_out_enable_in, start_in, chain_enable_in} = 4'h0;
		{power_down_n_in, reset_n_in, sample_valid_in, pin_write_valid_in} = 4'hC;
		first_config_register_in = 8'h00;
		channel_power_down_in = 8'h80;
		sample_in = SET_B;
		faults_in = {8'h5A, 8'hC3};
		pin_write_in = 8'hF0;
		gpio_drv = 4'hA;
		exp_a = make_frame(SET_A, 4'hA);
		exp_b = make_frame(SET_B, 4'hA);
		repeat (6) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (24) @(negedge clk_in);
		t_setup();
		t_reads();
		t_on_demand();
		t_control();
		give_verdict();
	end
endmodule
`default_nettype wire
